/* verilog/dbgp_port.sv */
`timescale 1ns/10ps
module dbgp_port (
    // Clocks and reset
    input  wire logic                      clk_i,
    input  wire logic                      reset_i,
    input  wire logic                      test_clock_i,
    // Debug serial pins
    input  wire logic                      dbg_serial_clock_i,
    input  wire logic                      dbg_serial_in_i,
    output logic                           dbg_serial_out_o,
    // Response words from the debug engine
    input  wire logic [dbgp_pkg::PKT_W-1:0] rsp_data_i,
    input  wire logic                      rsp_valid_i,
    output logic                           rsp_ready_o,
    // Received packets
    output logic [dbgp_pkg::PKT_W-1:0]     rx_word_o,
    output logic                           rx_valid_o,
    // Breakpoint and run control
    input  wire logic                      breakpoint_request_i,
    input  wire logic                      breakpoint_disable_i,
    input  wire logic                      trace_quiet_i,
    input  wire logic                      instr_done_i,
    input  wire logic                      resume_i,
    output logic                           halted_o,
    output logic                           debug_irq_o,
    // Core trace sources
    input  wire logic [3:0]                core_status_i,
    input  wire logic [3:0]                core_ddata_i,
    // Trace pins
    output logic [3:0]                     processor_status_o,
    output logic [3:0]                     debug_data_bus_o,
    output logic                           status_clock_o,
    output logic                           status_all_ones_o,
    // Boundary scan output, test clock domain
    input  wire logic                      scan_shift_ir_i,
    input  wire logic                      scan_shift_dr_i,
    input  wire logic                      scan_data_i,
    output logic                           scan_out_o,
    output logic                           scan_out_oe_o
);
    // ======================================================
    // Declarations
    // ======================================================
    dbgp_pkg::dbgp_state_t          q;          // Main state
    dbgp_pkg::dbgp_state_t          next_q;     // Next main state
    dbgp_pkg::dbgp_scan_t           s;          // Scan state
    dbgp_pkg::dbgp_scan_t           next_s;     // Next scan state
    // Serial engine helpers
    logic                           rise;       // Validated clock rise
    logic                           breakpoint_request_rise;  // Breakpoint request edge
    logic                           fifo_pop;   // Take next response
    logic                           fifo_valid; // Response waiting
    logic [dbgp_pkg::PKT_W-1:0]     fifo_data;  // Head response
    logic [dbgp_pkg::PKT_W-1:0]     word;       // Word for the shifter
    logic [dbgp_pkg::PKT_W-1:0]     rx_new;     // Receive shift result

    // ======================================================
    // Response buffer
    // ======================================================
    // Drained one word per packet, so a slow link fills it
    // Ready leaves a flop, so the engine may push freely
    dbgp_fifo #(
        .W     (dbgp_pkg::PKT_W),
        .DEPTH (dbgp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i      (clk_i),
        .reset_i    (reset_i),
        .wr_data_i  (rsp_data_i),
        .wr_valid_i (rsp_valid_i),
        .wr_ready_o (rsp_ready_o),
        .rd_data_o  (fifo_data),
        .rd_valid_o (fifo_valid),
        .rd_ready_i (fifo_pop)
    );

    // ======================================================
    // Main domain next state
    // ======================================================
    always_comb begin
        next_q = q;
        // Idle fill is zero when no response waits
        word   = '0;
        rx_new = {q.rx_shift[dbgp_pkg::PKT_W-2:0], q.din_sync[1]};
        // Edge seen one cycle after validation, so output lags it
        rise      = q.clk_level && !q.lvl_d;
        // Breakpoint acts on its rising edge only
        breakpoint_request_rise = q.breakpoint_request_sync[1] && !q.breakpoint_request_sync[2];
        // Pop at packet start; an empty buffer sends zeros
        fifo_pop  = rise && (q.bit_cnt == dbgp_pkg::CNT_FIRST);

        // Pin synchronizers; first stage feeds only the second
        next_q.clk_sync  = {q.clk_sync[1:0], dbg_serial_clock_i};
        next_q.din_sync  = {q.din_sync[0], dbg_serial_in_i};
        next_q.breakpoint_request_sync = {q.breakpoint_request_sync[1:0], breakpoint_request_i};
        // Level accepted only when two samples agree
        if (q.clk_sync[1] == q.clk_sync[2]) begin
            next_q.clk_level = q.clk_sync[2];
        end
        // Previous level, for the edge detector
        next_q.lvl_d    = q.clk_level;
        // Pulses last one cycle unless set below
        next_q.rx_valid = 1'b0;
        next_q.irq      = 1'b0;

        // Serial engine on each validated rising edge
        if (rise) begin
            next_q.rx_shift = rx_new;
            // Last bit closes the packet
            if (q.bit_cnt == dbgp_pkg::PKT_LAST) begin
                next_q.bit_cnt  = dbgp_pkg::CNT_FIRST;
                next_q.rx_word  = rx_new;
                next_q.rx_valid = 1'b1;
            end else begin
                next_q.bit_cnt = q.bit_cnt + dbgp_pkg::CNT_STEP;
            end
            // New packet starts: load response or idle zeros
            if (q.bit_cnt == dbgp_pkg::CNT_FIRST) begin
                if (fifo_valid) begin
                    word = fifo_data;
                end
                next_q.dout     = word[dbgp_pkg::PKT_W-1];
                next_q.tx_shift = word << 1;
            end else begin
                next_q.dout     = q.tx_shift[dbgp_pkg::PKT_W-1];
                next_q.tx_shift = q.tx_shift << 1;
            end
        end

        // Run control; triggers act even while trace is quiet
        case (q.run)
            dbgp_pkg::DBGP_RUN: begin
                if (breakpoint_request_rise && !breakpoint_disable_i) begin
                    next_q.run = dbgp_pkg::DBGP_PEND;
                end
            end
            dbgp_pkg::DBGP_PEND: begin
                if (instr_done_i) begin
                    next_q.run = dbgp_pkg::DBGP_HALT;
                end
            end
            dbgp_pkg::DBGP_HALT: begin
                // Host releases the core with resume
                if (resume_i) begin
                    next_q.run = dbgp_pkg::DBGP_RUN;
                end
            end
            default: begin
                // Illegal code falls back to running
                next_q.run = dbgp_pkg::DBGP_RUN;
            end
        endcase
        // Disabled breakpoint becomes an exception, no halt
        if (breakpoint_request_rise && breakpoint_disable_i) begin
            next_q.irq = 1'b1;
        end
        // Halt flag registered so the pin leaves a flop
        next_q.halted = next_q.run == dbgp_pkg::DBGP_HALT;

        // Trace: two core cycles per beat, clock rises mid beat
        if (!trace_quiet_i) begin
            // Beat phase advances only while trace runs
            next_q.phase = !q.phase;
            if (!q.phase) begin
                // Data changes while the status clock is low
                next_q.trace.sclk = 1'b0;
                if (q.halted) begin
                    next_q.trace.status = dbgp_pkg::PST_HALT;
                end else begin
                    next_q.trace.status = core_status_i;
                end
                next_q.trace.ddata    = core_ddata_i;
                next_q.trace.all_ones = &next_q.trace.status;
                if (next_q.trace.status == dbgp_pkg::PST_HALT
                    || next_q.trace.status == dbgp_pkg::PST_RST_C
                    || next_q.trace.status == dbgp_pkg::PST_RST_D) begin
                    // Start latch holds until the next reset
                    next_q.started = 1'b1;
                end
            end else begin
                // Clock stays idle until a reset or halt code was shown
                next_q.trace.sclk = q.started;
            end
        end
    end

    // ======================================================
    // Main domain registers
    // ======================================================
    // Serial output starts low after reset
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            q     <= '0;
            // Run control wakes in the running state
            q.run <= dbgp_pkg::DBGP_RUN;
        end else begin
            q <= next_q;
        end
    end

    // ======================================================
    // Test clock domain: boundary scan output
    // ======================================================
    // Halt level crosses by two flops; capture loads it
    always_comb begin
        next_s           = s;
        next_s.halt_sync = {s.halt_sync[0], q.halted};
        next_s.oe        = scan_shift_ir_i || scan_shift_dr_i;
        // Shifting moves capture to out and input to capture
        if (next_s.oe) begin
            next_s.out = s.cap;
            next_s.cap = scan_data_i;
        end else begin
            // Otherwise capture samples the halted level
            next_s.cap = s.halt_sync[1];
        end
    end

    // Falling edge update keeps setup to the far side's rise
    always_ff @(negedge test_clock_i or posedge reset_i) begin
        if (reset_i) begin
            // Reset drops the driver enable, pin floats
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ======================================================
    // Outputs, all straight from flops
    // ======================================================
    assign dbg_serial_out_o   = q.dout;
    assign rx_word_o          = q.rx_word;
    assign rx_valid_o         = q.rx_valid;
    assign halted_o           = q.halted;
    assign debug_irq_o        = q.irq;
    // Trace pins
    assign processor_status_o = q.trace.status;
    assign debug_data_bus_o   = q.trace.ddata;
    assign status_clock_o     = q.trace.sclk;
    assign status_all_ones_o  = q.trace.all_ones;
    // Scan pins
    assign scan_out_o         = s.out;
    assign scan_out_oe_o      = s.oe;

    // ======================================================
    // Assertions
    // ======================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // Core clock checks are muted while reset holds
    // Serial link checks

    a_level_two_samples: assert property (
        q.clk_level != $past(q.clk_level)
        |-> $past(q.clk_sync[1]) == $past(q.clk_sync[2]))
        else $error("serial clock level taken without agreement");
    a_input_sampled: assert property (
        rise |=> q.rx_shift[0] == $past(q.din_sync[1]))
        else $error("serial input not sampled on rise");
    a_rx_complete: assert property (
        rx_valid_o |-> $past(rise)
        && $past(q.bit_cnt) == dbgp_pkg::PKT_LAST)
        else $error("packet ended off its last bit");
    a_output_lags: assert property (
        $changed(dbg_serial_out_o)
        |-> $past(q.clk_level) && !$past(q.lvl_d))
        else $error("serial output moved off a validated rise");
    // Run control, trace and scan enable checks
    a_halt_entry: assert property (
        q.run == dbgp_pkg::DBGP_PEND && instr_done_i
        |=> halted_o)
        else $error("halt not entered after instruction");
    a_breakpoint_request_pending: assert property (
        breakpoint_request_rise && !breakpoint_disable_i
        && q.run == dbgp_pkg::DBGP_RUN
        |=> q.run == dbgp_pkg::DBGP_PEND)
        else $error("breakpoint did not request halt");
    a_halt_status: assert property (
        halted_o && !q.phase && !trace_quiet_i
        |=> processor_status_o == dbgp_pkg::PST_HALT)
        else $error("halted status not all ones");
    a_breakpoint_request_irq: assert property (
        breakpoint_request_rise && breakpoint_disable_i
        |=> debug_irq_o && q.run != dbgp_pkg::DBGP_PEND)
        else $error("disabled breakpoint gave no interrupt");
    a_irq_pulse: assert property (
        debug_irq_o |=> !debug_irq_o)
        else $error("debug interrupt longer than one cycle");
    a_ddata_follow: assert property (
        !q.phase && !trace_quiet_i
        |=> debug_data_bus_o == $past(core_ddata_i))
        else $error("debug data not captured");
    a_sclk_center: assert property (
        $changed(processor_status_o) |-> !status_clock_o
        ##1 (status_clock_o || !q.started || trace_quiet_i))
        else $error("status clock not centered");
    a_quiet_freeze: assert property (
        trace_quiet_i |=> $stable(processor_status_o)
        && $stable(debug_data_bus_o) && $stable(status_clock_o))
        else $error("trace moved while quiet");
    a_sclk_idle: assert property (
        !q.started |-> !status_clock_o)
        else $error("status clock ran before reset code");
    a_all_ones: assert property (
        status_all_ones_o == (&processor_status_o))
        else $error("all-ones output wrong");
    a_scan_enable: assert property (
        @(negedge test_clock_i) disable iff (reset_i)
        scan_out_oe_o == $past(scan_shift_ir_i || scan_shift_dr_i))
        else $error("scan output enable outside shift states");
    // Shifted bit is the one captured one fall earlier
    a_scan_shift: assert property (
        @(negedge test_clock_i) disable iff (reset_i)
        scan_out_oe_o |-> scan_out_o == $past(s.cap))
        else $error("scan output not moved on test clock fall");

    // Main scenarios reached

    c_halted: cover property (q.run == dbgp_pkg::DBGP_HALT);
    c_irq: cover property (debug_irq_o);
    c_packet: cover property (rx_valid_o);
    c_resp_sent: cover property (fifo_pop && fifo_valid);
    c_trace_start: cover property ($rose(q.started));
endmodule // dbgp_port

/* verilog/dbgp_pkg.sv */
// ==========================================================
// Shared constants and carriers of the debug serial and trace
// ==========================================================
package dbgp_pkg;
    // Serial packet width and bit counter width
    localparam int              PKT_W      = 17;
    localparam int              CNT_W      = 5;
    localparam logic [CNT_W-1:0] CNT_FIRST = 5'h00;
    localparam logic [CNT_W-1:0] PKT_LAST  = 5'(PKT_W - 1);
    localparam logic [CNT_W-1:0] CNT_STEP  = 5'h01;
    // Response buffer depth
    localparam int              FIFO_DEPTH = 8;
    // Far side must keep serial clock at or below status clock / 5
    localparam int              DBG_SERIAL_CLOCK_DIV  = 5;
    // Status codes: halted and the two reset codes, all three start trace
    localparam logic [3:0]      PST_HALT   = 4'hF;
    localparam logic [3:0]      PST_RST_C  = 4'hC;
    localparam logic [3:0]      PST_RST_D  = 4'hD;

    // Run control, one-hot
    typedef enum logic [2:0] {
        DBGP_RUN  = 3'b001,
        DBGP_PEND = 3'b010,
        DBGP_HALT = 3'b100
    } dbgp_run_t;

    // Trace pins as one group
    typedef struct packed {
        logic [3:0] status;
        logic [3:0] ddata;
        logic       sclk;
        logic       all_ones;
    } dbgp_trace_t;

    // Whole state of the main clock domain
    typedef struct packed {
        logic [2:0]       clk_sync;
        logic             clk_level;
        logic             lvl_d;
        logic [1:0]       din_sync;
        logic [2:0]       breakpoint_request_sync;
        logic [CNT_W-1:0] bit_cnt;
        logic [PKT_W-1:0] rx_shift;
        logic [PKT_W-1:0] tx_shift;
        logic [PKT_W-1:0] rx_word;
        logic             rx_valid;
        logic             dout;
        dbgp_run_t        run;
        logic             halted;
        logic             irq;
        logic             phase;
        logic             started;
        dbgp_trace_t      trace;
    } dbgp_state_t;

    // Whole state of the test clock domain
    typedef struct packed {
        logic [1:0] halt_sync;
        logic       cap;
        logic       out;
        logic       oe;
    } dbgp_scan_t;
endpackage

/* verilog/dbgp_fifo.sv */
`timescale 1ns/10ps
// ==========================================================
// Response buffer: simple synchronous FIFO
// ==========================================================
module dbgp_fifo #(
    parameter int W     = dbgp_pkg::PKT_W,
    parameter int DEPTH = dbgp_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    // Fill side
    input  wire logic [W-1:0] wr_data_i,
    input  wire logic         wr_valid_i,
    output logic              wr_ready_o,
    // Drain side
    output logic [W-1:0]      rd_data_o,
    output logic              rd_valid_o,
    input  wire logic         rd_ready_i
);
    localparam int          AW   = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    // Pointer state; depth must be a power of two
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
        logic          space;
        logic          avail;
    } dbgp_fptr_t;

    logic [W-1:0] mem [DEPTH];  // Storage words
    dbgp_fptr_t   q;            // Current pointers
    dbgp_fptr_t   next_q;       // Next pointers
    logic         push;         // Word accepted
    logic         pop;          // Word taken

    // Flags are registered so ready and valid leave flops directly
    always_comb begin
        push   = wr_valid_i && q.space;
        pop    = rd_ready_i && q.avail;
        next_q = q;
        if (push) begin
            next_q.wp = q.wp + 1'b1;
        end
        if (pop) begin
            next_q.rp = q.rp + 1'b1;
        end
        next_q.cnt   = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        next_q.space = next_q.cnt != FULL;
        next_q.avail = next_q.cnt != '0;
    end

    // Pointer registers
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            q       <= '0;
            q.space <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // Storage write, no reset needed
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[q.wp] <= wr_data_i;
        end
    end

    assign wr_ready_o = q.space;
    assign rd_valid_o = q.avail;
    assign rd_data_o  = mem[q.rp];
endmodule // dbgp_fifo

/* tb/dbgp_probe.sv */
`timescale 1ns/10ps
// ==========================================================
// Debugger probe on the far side of the serial link
// ==========================================================
module dbgp_probe (
    // Core clock, only times the done pulse
    input  wire logic        clk_i,
    // Serial pins
    output logic             dbg_serial_clock_o,
    output logic             dbg_serial_in_o,
    input  wire logic        dbg_serial_out_i,
    // Captured response word
    output logic [16:0]      word_o,
    output logic             done_o
);
    // Serial clock stands low outside packets
    initial begin
        dbg_serial_clock_o = 1'b0;
        dbg_serial_in_o = 1'b1;
        word_o = 17'h00000;
        done_o = 1'b0;
    end

    // One packet, MSB first; low 60 ns, high 80 ns
    // Period of 140 ns stays below status clock / 5
    task automatic xfer(input logic [16:0] tx);
        for (int i = 16; i >= 0; i--) begin
            dbg_serial_in_o = tx[i];
            #60 dbg_serial_clock_o = 1'b1;
            #80 word_o[i] = dbg_serial_out_i;
            dbg_serial_clock_o = 1'b0;
        end
        // Idle data line flips, so a stale bit never reads as valid
        dbg_serial_in_o = ~tx[0];
        @(posedge clk_i) #1 done_o = 1'b1;
        @(posedge clk_i) #1 done_o = 1'b0;
    endtask
endmodule // dbgp_probe

/* tb/tb.sv */
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench of the debug serial and trace port
// ==========================================================
module tb;
    // Clocks, reset and pins
    logic        clk_i = 1'b0, tck = 1'b0, reset_i = 1'b1;
    logic        dbg_serial_clock, dsi, dbg_serial_out, rsp_valid, rsp_ready, rx_valid;
    logic [16:0] rsp_data, rx_word, pw, w, snap;
    logic        bp_req, bp_dis, quiet, idone, resume, halted, irq;
    logic [3:0]  cst, cdd, pst, dd;
    logic        sclk, status_all_ones, s_ir, s_dr, s_d, s_o, s_oe, pdone, prev_h;
    logic        d [12];
    // Score keeping and expectation queues
    int          mismatches = 0, tests_run = 0, seed = 97508;
    logic [16:0] exp_rx [$], exp_so [$];
    logic [1:0]  exp_ev [$];

    // Core clock 10 ns, test clock 12 ns, unrelated phase
    always #5 clk_i = ~clk_i;
    always #6 tck = ~tck;

    // ==========================================================
    // Design and far side
    // ==========================================================
    dbgp_port dbgp_port_i (
        .clk_i(clk_i), .reset_i(reset_i), .test_clock_i(tck),
        .dbg_serial_clock_i(dbg_serial_clock), .dbg_serial_in_i(dsi),
        .dbg_serial_out_o(dbg_serial_out), .rsp_data_i(rsp_data),
        .rsp_valid_i(rsp_valid), .rsp_ready_o(rsp_ready),
        .rx_word_o(rx_word), .rx_valid_o(rx_valid),
        .breakpoint_request_i(bp_req), .breakpoint_disable_i(bp_dis),
        .trace_quiet_i(quiet), .instr_done_i(idone), .resume_i(resume),
        .halted_o(halted), .debug_irq_o(irq), .core_status_i(cst),
        .core_ddata_i(cdd), .processor_status_o(pst),
        .debug_data_bus_o(dd), .status_clock_o(sclk),
        .status_all_ones_o(status_all_ones), .scan_shift_ir_i(s_ir),
        .scan_shift_dr_i(s_dr), .scan_data_i(s_d), .scan_out_o(s_o),
        .scan_out_oe_o(s_oe));

    dbgp_probe dbgp_probe_i (
        .clk_i(clk_i), .dbg_serial_clock_o(dbg_serial_clock), .dbg_serial_in_o(dsi),
        .dbg_serial_out_i(dbg_serial_out), .word_o(pw), .done_o(pdone));

    // ==========================================================
    // Shared tasks
    // ==========================================================
    // Compare and count
    task automatic cmp(input string nm, input logic [16:0] e, g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    // Verdict and end of run
    task automatic summarize;
        if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Drive point: just after a core clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Bounded wait; running out counts and ends the run
    task automatic wait_on(ref logic s, input logic v, input string nm);
        for (int k = 0; k < 400 && s !== v; k++) tick(1);
        if (s !== v) begin
            cmp(nm, {16'h0000, v}, {16'h0000, s});
            summarize();
        end
    endtask

    // Two status clock rises, so a fresh beat is loaded
    task automatic beat;
        repeat (2) begin
            wait_on(sclk, 1'b0, "status_clock");
            wait_on(sclk, 1'b1, "status_clock");
        end
    endtask

    // ==========================================================
    // Monitor: results are matched with the oldest note
    // ==========================================================
    always @(posedge clk_i) begin
        if (rx_valid === 1'b1)
            cmp("rx_word", exp_rx.pop_front(), rx_word);
        if (pdone === 1'b1)
            cmp("serial_out", exp_so.pop_front(), pw);
        if ((halted === 1'b1 && prev_h !== 1'b1) || irq === 1'b1)
            cmp("breakpoint_request", exp_ev.pop_front(), {irq, halted});
        if (reset_i === 1'b0)
            cmp("all_ones", {16'h0000, &pst}, {16'h0000, status_all_ones});
        prev_h <= halted;
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        {rsp_valid, bp_req, bp_dis, quiet, idone, resume} = 6'h00;
        {s_ir, s_dr, s_d} = 3'h0;
        rsp_data = 17'h00000;
        cst = 4'h0;
        cdd = 4'h0;
        tick(16);
        reset_i = 1'b0;
        // Non-start codes only: status clock must stay idle
        repeat (20) begin
            cst = 4'($unsigned($random(seed))) % 4'hC;
            tick(1);
            cmp("sclk_idle", 17'h00000, {16'h0000, sclk});
        end
        // Reset code starts trace; beats carry fresh values
        cst = 4'hC;
        repeat (4) begin
            beat();
            cmp("status", {13'h0000, cst}, {13'h0000, pst});
            cmp("ddata", {13'h0000, cdd}, {13'h0000, dd});
            cst = 4'($random(seed));
            cdd = 4'($random(seed));
        end
        // Quiet trace freezes pins, breakpoint still raises irq
        quiet = 1'b1;
        tick(2);
        snap = {8'h00, pst, dd, sclk};
        bp_dis = 1'b1;
        bp_req = 1'b1;
        exp_ev.push_back(2'b10);
        cst = ~cst;
        repeat (12) begin
            tick(1);
            cmp("quiet", snap, {8'h00, pst, dd, sclk});
        end
        cmp("debug_irq", 17'h00000, 17'(exp_ev.size()));
        bp_req = 1'b0;
        quiet = 1'b0;
        // Resynchronize on the status clock before reading
        beat();
        cmp("status_after_quiet", {13'h0000, cst}, {13'h0000, pst});
        // Breakpoint halts only once the instruction completes
        bp_dis = 1'b0;
        bp_req = 1'b1;
        exp_ev.push_back(2'b01);
        tick(8);
        cmp("early_halt", 17'h00000, {16'h0000, halted});
        idone = 1'b1;
        wait_on(halted, 1'b1, "halted");
        idone = 1'b0;
        bp_req = 1'b0;
        beat();
        cmp("halt_status", 17'h0000F, {13'h0000, pst});
        resume = 1'b1;
        wait_on(halted, 1'b0, "resume");
        resume = 1'b0;
        // Empty buffer: a packet answers with zeros
        cmp("dso_idle", 17'h00000, {16'h0000, dbg_serial_out});
        w = 17'($random(seed));
        exp_rx.push_back(w);
        exp_so.push_back(17'h00000);
        dbgp_probe_i.xfer(w);
        // Fill the buffer until it refuses the ninth word
        for (int i = 0; i < 9; i++) begin
            rsp_data = 17'($random(seed));
            rsp_valid = 1'b1;
            if (rsp_ready === 1'b1) exp_so.push_back(rsp_data);
            tick(1);
        end
        rsp_valid = 1'b0;
        cmp("fifo_taken", 17'd8, 17'(exp_so.size()));
        // Drain it packet by packet, then one more gives zeros
        for (int i = 0; i < 9; i++) begin
            if (i == 8) exp_so.push_back(17'h00000);
            w = 17'($random(seed));
            exp_rx.push_back(w);
            dbgp_probe_i.xfer(w);
        end
        // Scan shift: driven only while shifting, moves on falls
        for (int i = 0; i < 12; i++) begin
            @(posedge tck) #1;
            s_ir = (i < 6);
            s_dr = (i >= 6);
            d[i] = 1'($random(seed));
            s_d = d[i];
            snap = {16'h0000, s_o};
            #4 cmp("scan_hold", snap, {16'h0000, s_o});
            @(negedge tck) #1;
            cmp("scan_oe", 17'h00001, {16'h0000, s_oe});
            if (i > 0) cmp("scan_out", {16'h0000, d[i-1]}, {16'h0000, s_o});
        end
        @(posedge tck) #1;
        {s_ir, s_dr} = 2'b00;
        @(negedge tck) #1;
        cmp("scan_off", 17'h00000, {16'h0000, s_oe});
        tick(40);
        summarize();
    end
endmodule // tb
